// *** rtl/bbc_top.sv ***
// backlight brightness engine: ahb-lite registers, ramps, adaptive scaling
//
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module bbc_top
  import bbc_pkg::*;
#(
  parameter int RAMP_MS  = RAMP_TIME_MS,
  parameter int RAMP_CYCLES = RAMP_MS * CYC_PER_MS
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        soft_reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sleep_in,
  input  wire logic [7:0]  content_ratio,
  output logic [1:0]       adaptive_mode,
  output logic             adapt_active,
  output logic [7:0]       gray_gain,
  output logic [7:0]       backlight_level
);

  // short ramps step coarsely and hold each level; long ones step finely
  localparam int STEPS_LOG2 = (RAMP_MS < HOLD_LIMIT_MS) ? STEPS_LOG2_HOLD : STEPS_LOG2_FINE;
  localparam int SLOT_CYC   = RAMP_CYCLES >> STEPS_LOG2;

  bbc_regs_t  rg_r;
  bbc_regs_t  rg_nxt;
  logic       addr_ok;
  logic [7:0] man_lvl;
  logic [7:0] ratio_lvl;
  logic [7:0] ratio_tgt;
  logic       man_busy;
  logic       ratio_busy;
  logic       floor_hit;
  logic       adapt_on;
  logic [31:0] rd_word;

  // ************************************************************
  // bus slave: zero wait states, always okay
  // ************************************************************
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && hready && htrans[1];

  // register read mux, sampled in the address phase so hrdata is a flop
  always_comb begin
    rd_word = 32'h0;
    unique case (haddr[7:0])
      ADDR_MANUAL: rd_word[7:0] = rg_r.manual;
      ADDR_CTRL: begin
        rd_word[CTRL_BL_BIT]    = rg_r.bl_on;
        rd_word[CTRL_DIM_BIT]   = rg_r.dim_en;
        rd_word[CTRL_BACKLIGHT_CONTROL_ENABLE_BIT] = rg_r.backlight_control_enable;
      end
      ADDR_MODE:   rd_word[1:0] = rg_r.mode;
      // floor reads back as written, in any mode or sleep state
      ADDR_FLOOR:  rd_word[7:0] = rg_r.floor_lvl;
      ADDR_STATUS: begin
        rd_word[7:0]          = backlight_level;
        rd_word[ST_RAMP_BIT]  = man_busy;
        rd_word[ST_ADAPT_BIT] = adapt_on;
        rd_word[ST_FLOOR_BIT] = floor_hit;
        rd_word[ST_CRAMP_BIT] = ratio_busy;
      end
      default:     rd_word = 32'h0;
    endcase
    if (haddr[31:8] != 24'h0) begin
      rd_word = 32'h0;
    end
  end

  // ************************************************************
  // register state: address phase capture, data phase write
  // ************************************************************
  always_comb begin
    rg_nxt         = rg_r;
    rg_nxt.wr_pend = 1'b0;
    if (rg_r.wr_pend) begin
      unique case (rg_r.wr_addr)
        ADDR_MANUAL: rg_nxt.manual = hwdata[7:0];
        ADDR_CTRL: begin
          rg_nxt.bl_on  = hwdata[CTRL_BL_BIT];
          rg_nxt.dim_en = hwdata[CTRL_DIM_BIT];
          rg_nxt.backlight_control_enable  = hwdata[CTRL_BACKLIGHT_CONTROL_ENABLE_BIT];
        end
        ADDR_MODE:  rg_nxt.mode      = bbc_mode_t'(hwdata[1:0]);
        ADDR_FLOOR: rg_nxt.floor_lvl = hwdata[7:0];
        default:    rg_nxt.floor_lvl = rg_r.floor_lvl;
      endcase
    end
    if (addr_ok) begin
      rg_nxt.wr_pend = hwrite && (haddr[31:8] == 24'h0);
      rg_nxt.wr_addr = haddr[7:0];
      rg_nxt.rdata   = hwrite ? 32'h0 : rd_word;
    end
    if (soft_reset) begin
      // software reset returns every control to its default
      rg_nxt           = '0;
      rg_nxt.manual    = MANUAL_RST;
      rg_nxt.floor_lvl = FLOOR_RST;
      rg_nxt.mode      = bbc_mode_t'(MODE_RST);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rg_r           <= '0;
      rg_r.manual    <= MANUAL_RST;
      rg_r.floor_lvl <= FLOOR_RST;
      rg_r.mode      <= bbc_mode_t'(MODE_RST);
    end else begin
      rg_r <= rg_nxt;
    end
  end

  assign hrdata = rg_r.rdata;

  // ************************************************************
  // adaptation: off in mode 00, in sleep-in, or with control disabled
  // ************************************************************
  assign adapt_on  = (rg_r.mode != BBC_MODE_OFF) && !sleep_in && rg_r.backlight_control_enable;
  // the ratio follows the content analysis for whole or partial frames alike
  assign ratio_tgt = adapt_on ? content_ratio : FULL_SCALE;

  // manual level ramps only when dimming is enabled
  bbc_ramp #(
    .STEPS_LOG2 (STEPS_LOG2),
    .SLOT_CYC   (SLOT_CYC)
  ) u_man_ramp (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clr     (soft_reset),
    .en      (rg_r.dim_en),
    .target  (rg_r.manual),
    .level   (man_lvl),
    .busy    (man_busy)
  );

  // adaptive ratio always moves smoothly; both ramps run side by side, so
  // a joint change ends no later than the two ramp times added
  bbc_ramp #(
    .STEPS_LOG2 (STEPS_LOG2),
    .SLOT_CYC   (SLOT_CYC)
  ) u_ratio_ramp (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clr     (soft_reset),
    .en      (1'b1),
    .target  (ratio_tgt),
    .level   (ratio_lvl),
    .busy    (ratio_busy)
  );

  // floor acts after both ramps, so it never interrupts either one
  bbc_scale u_scale (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clr       (soft_reset),
    .on        (rg_r.backlight_control_enable),
    .floor_en  (adapt_on),
    .manual    (man_lvl),
    .ratio     (ratio_lvl),
    .floor_lvl (rg_r.floor_lvl),
    .level     (backlight_level),
    .floor_hit (floor_hit)
  );

  // ************************************************************
  // pixel side: gray gain is the same ratio the backlight loses
  // ************************************************************
  // gain keeps tracking even while the floor holds the backlight still
  assign gray_gain     = ratio_lvl;
  assign adaptive_mode = rg_r.mode;
  assign adapt_active  = adapt_on;

endmodule

// *** common/bbc_pkg.sv ***
// package of the backlight brightness engine: constants, register map and state types
// Functional notes
// - a dimming-enable bit switches the linear ramp on or off.
// - with dimming on, a change takes 400 to 600 ms end to end.
// - the ramp advances in equal time steps, so brightness moves linearly.
// - rising and falling changes use the same ramp shape.
// - ramps under 500 ms hold each step; longer ramps step without holding.
// - two-bit adaptive mode; 00 off, 01/10/11 user-interface, still, moving content.
// - adaptation raises gray scale while lowering backlight by the same ratio.
// - output brightness is manual level times the adaptive ratio, before flooring.
// - a joint adaptive and manual change ends within both ramp times summed.
// - while adapting, output never drops below the adaptive floor level.
// - the floor does not limit a manual level set below it.
// - with backlight control disabled the floor level is ignored.
// - reading the floor always returns the last written floor value; a soft reset sets it back to FLOOR_RST instead.
// - the floor is an eight-bit level on a full scale of 255.
// - the floor leaves smooth transitions and the dimming ramp working.
// - gray processing may continue while the floor blocks further dimming.
// - adaptation keeps working when only part of the image is updated.
// - the floor is one eight-bit value with its own write and read.
// - manual brightness is an eight-bit value with its own write and read.
package bbc_pkg;

  // ************************************************************
  // clock and ramp timing
  // ************************************************************
  localparam int CLK_HZ        = 125_000_000;
  localparam int CYC_PER_MS    = CLK_HZ / 1000;
  localparam int DIM_MIN_MS    = 400;
  localparam int DIM_MAX_MS    = 600;
  localparam int HOLD_LIMIT_MS = 500;
  localparam int RAMP_TIME_MS  = 500;
  localparam int RAMP_CYC      = RAMP_TIME_MS * CYC_PER_MS;
  localparam int STEPS_LOG2_HOLD = 4;
  localparam int STEPS_LOG2_FINE = 8;

  // ************************************************************
  // register map (byte addresses) and field positions
  // ************************************************************
  localparam logic [7:0] ADDR_MANUAL = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_MODE   = 8'h08;
  localparam logic [7:0] ADDR_FLOOR  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam int CTRL_BL_BIT    = 2;
  localparam int CTRL_DIM_BIT   = 3;
  localparam int CTRL_BACKLIGHT_CONTROL_ENABLE_BIT = 5;
  localparam int ST_RAMP_BIT    = 8;
  localparam int ST_ADAPT_BIT   = 9;
  localparam int ST_FLOOR_BIT   = 10;
  localparam int ST_CRAMP_BIT   = 11;

  // ************************************************************
  // reset values and scale
  // ************************************************************
  localparam logic [7:0] MANUAL_RST = 8'h00;
  localparam logic [7:0] FLOOR_RST  = 8'h00;
  localparam logic [1:0] MODE_RST   = 2'h0;
  localparam logic [7:0] FULL_SCALE = 8'hff;

  typedef enum logic [1:0] {
    BBC_MODE_OFF    = 2'b00,
    BBC_MODE_UI     = 2'b01,
    BBC_MODE_STILL  = 2'b10,
    BBC_MODE_MOVING = 2'b11
  } bbc_mode_t;

  typedef struct packed {
    logic        active;
    logic [7:0]  cur;
    logic [7:0]  start;
    logic [7:0]  tgt;
    logic [8:0]  k;
    logic [31:0] cnt;
  } bbc_ramp_st_t;

  typedef struct packed {
    logic [7:0] level;
    logic       hit;
  } bbc_scale_st_t;

  typedef struct packed {
    logic [7:0]  manual;
    logic        bl_on;
    logic        dim_en;
    logic        backlight_control_enable;
    bbc_mode_t   mode;
    logic [7:0]  floor_lvl;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
  } bbc_regs_t;

endpackage

// *** rtl/bbc_ramp.sv ***
// linear brightness ramp from the present level to a new target
`timescale 1ns/1ps
module bbc_ramp
  import bbc_pkg::*;
#(
  parameter int STEPS_LOG2 = STEPS_LOG2_FINE,
  parameter int SLOT_CYC   = RAMP_CYC >> STEPS_LOG2_FINE
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       clr,
  input  wire logic       en,
  input  wire logic [7:0] target,
  output logic [7:0]      level,
  output logic            busy
);

  localparam logic [8:0]  STEPS    = 9'(1 << STEPS_LOG2);
  localparam logic [31:0] SLOT_END = 32'((SLOT_CYC < 1) ? 0 : SLOT_CYC - 1);

  bbc_ramp_st_t st_r;
  bbc_ramp_st_t st_nxt;
  logic signed [9:0]  diff;
  logic signed [20:0] prod;
  logic signed [20:0] sum;
  logic [8:0]         kn;

  // ************************************************************
  // next state: restart on a new target, one equal slot per step
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    kn     = st_r.k + 9'h001;
    diff   = $signed({2'b00, st_r.tgt}) - $signed({2'b00, st_r.start});
    // widen both factors first so the product cannot wrap at ten bits
    prod   = $signed({{11{diff[9]}}, diff}) * $signed({12'h000, kn});
    sum    = $signed({13'h0000, st_r.start}) + (prod >>> STEPS_LOG2);
    if (clr) begin
      st_nxt = '0;
    end else if (!en) begin
      // without dimming the new level lands at once
      st_nxt.active = 1'b0;
      st_nxt.cur    = target;
      st_nxt.tgt    = target;
    end else if (target != st_r.tgt) begin
      // retarget from wherever the ramp stands now, same shape both ways
      st_nxt.start  = st_r.cur;
      st_nxt.tgt    = target;
      st_nxt.k      = 9'h000;
      st_nxt.cnt    = 32'h0;
      st_nxt.active = (target != st_r.cur);
    end else if (st_r.active) begin
      if (st_r.cnt >= SLOT_END) begin
        // equal slots; a coarse step count leaves each level standing a while
        st_nxt.cnt = 32'h0;
        st_nxt.k   = kn;
        st_nxt.cur = sum[7:0];
        if (kn == STEPS) begin
          st_nxt.cur    = st_r.tgt;
          st_nxt.active = 1'b0;
        end
      end else begin
        st_nxt.cnt = st_r.cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.cur;
  assign busy  = st_r.active;

endmodule

// *** rtl/bbc_scale.sv ***
// product of manual level and adaptive ratio, with the adaptive floor
`timescale 1ns/1ps
module bbc_scale
  import bbc_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       clr,
  input  wire logic       on,
  input  wire logic       floor_en,
  input  wire logic [7:0] manual,
  input  wire logic [7:0] ratio,
  input  wire logic [7:0] floor_lvl,
  output logic [7:0]      level,
  output logic            floor_hit
);

  bbc_scale_st_t st_r;
  bbc_scale_st_t st_nxt;
  logic [15:0]   prod;
  logic [15:0]   quot;
  logic [7:0]    lim;

  // ************************************************************
  // level = manual * ratio / full scale, then clamp at the floor
  // ************************************************************
  always_comb begin
    prod   = manual * ratio;
    quot   = prod / {8'h00, FULL_SCALE};
    // a manual level under the floor is kept, so the floor never lifts it
    lim    = (manual < floor_lvl) ? manual : floor_lvl;
    st_nxt = '0;
    if (clr || !on) begin
      st_nxt = '0;
    end else if (floor_en && quot[7:0] < lim) begin
      st_nxt.level = lim;
      st_nxt.hit   = 1'b1;
    end else begin
      st_nxt.level = quot[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level     = st_r.level;
  assign floor_hit = st_r.hit;

endmodule

// *** test/bbc_chk.sv ***
// assertion checker of the backlight brightness engine, bound to its top
`timescale 1ns/1ps
module bbc_chk
  import bbc_pkg::*;
#(
  parameter int RAMP_MS     = RAMP_TIME_MS,
  parameter int RAMP_CYCLES = RAMP_CYC
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        soft_reset,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        sleep_in,
  input wire logic [1:0]  adaptive_mode,
  input wire logic        adapt_active,
  input wire logic [7:0]  gray_gain,
  input wire logic [7:0]  backlight_level
);
  // ********
  // helpers
  // ********
  localparam int LOG2    = RAMP_MS < HOLD_LIMIT_MS ? STEPS_LOG2_HOLD : STEPS_LOG2_FINE;
  localparam int SLOT    = (RAMP_CYCLES >> LOG2) < 1 ? 1 : RAMP_CYCLES >> LOG2;
  // a linear step moves at most full scale over the step count, rounded up
  localparam int MAXSTEP = (int'(FULL_SCALE) >> LOG2) + 1;
  logic        take;
  logic [7:0]  gprev_r;
  logic [31:0] gcnt_r;
  // an address phase the slave accepts
  assign take = hsel && hready && htrans[1];
  // cycles since the gain last moved; saturates so long idle never wraps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gprev_r <= 8'h00;
      gcnt_r  <= 32'hffffffff;
    end else begin
      gprev_r <= gray_gain;
      if (gray_gain != gprev_r) gcnt_r <= 32'h00000001;
      else if (gcnt_r != 32'hffffffff) gcnt_r <= gcnt_r + 32'h00000001;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence mode_wr_s;
    take && hwrite && haddr == {24'h000000, ADDR_MODE} ##1 hready;
  endsequence
  sequence stat_rd_s;
    take && !hwrite && haddr == {24'h000000, ADDR_STATUS};
  endsequence
  sequence bad_rd_s;
    take && !hwrite && (haddr[31:8] != 24'h000000 || haddr[7:0] > ADDR_STATUS);
  endsequence
  // ********
  // checks
  // ********
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_mode_idle: assert property (adaptive_mode == 2'b00 |-> !adapt_active)
    else $error("adaptation active with mode off");
  a_sleep_idle: assert property (sleep_in |-> !adapt_active)
    else $error("adaptation active in sleep");
  a_mode_write: assert property (mode_wr_s |=> {30'h0, adaptive_mode} == ($past(hwdata) & 32'h3))
    else $error("mode output does not follow write");
  a_status_mirror: assert property (stat_rd_s |=> hrdata[7:0] == $past(backlight_level)
    && hrdata[9] == $past(adapt_active))
    else $error("status read does not mirror outputs");
  a_bad_read: assert property (bad_rd_s |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_step_hold: assert property (RAMP_MS < HOLD_LIMIT_MS && gray_gain != gprev_r
    && !$past(soft_reset)
    |-> gcnt_r >= SLOT)
    else $error("ramp step held too briefly");
  a_step_size: assert property (!$past(soft_reset) |-> (gray_gain >= $past(gray_gain) ?
    gray_gain - $past(gray_gain) : $past(gray_gain) - gray_gain) <= MAXSTEP)
    else $error("ramp step too large");
endmodule
bind bbc_top bbc_chk #(.RAMP_MS(RAMP_MS), .RAMP_CYCLES(RAMP_CYCLES)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .soft_reset(soft_reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .sleep_in(sleep_in), .adaptive_mode(adaptive_mode),
  .adapt_active(adapt_active), .gray_gain(gray_gain), .backlight_level(backlight_level));

// *** test/bbc_light_model.sv ***
// behavioural backlight source that watches the luminance it is driven with
`timescale 1ns/1ps
module bbc_light_model (
  input wire logic       hclk,
  input wire logic       clr,
  input wire logic [7:0] level
);
  logic [7:0] lum;
  int         steps;
  int         hold;
  int         min_hold;
  int         max_hold;
  // count luminance steps and how long each level between two steps was held; a step held short shows as flicker
  always @(posedge hclk) begin
    if (clr) begin
      lum = level;
      steps = 0;
      min_hold = 32'h7fffffff;
      max_hold = 0;
    end else if (level != lum) begin
      if (steps > 0 && hold < min_hold) min_hold = hold;
      if (steps > 0 && hold > max_hold) max_hold = hold;
      steps++;
      hold = 1;
      lum = level;
    end else begin
      hold++;
    end
  end
endmodule

// *** test/bbc_top_bench.sv ***
// self-checking bench of the backlight brightness engine
`timescale 1ns/1ps
module bbc_top_bench import bbc_pkg::*;;
  localparam int RMS = 400;
  localparam int RCY = 160;
  localparam int NST = 1 << STEPS_LOG2_HOLD;
  localparam int SLT = RCY >> STEPS_LOG2_HOLD;
  logic        hclk, hresetn, soft_reset, hsel, hwrite, sleep_in, mdl_clr;
  logic        hreadyout, hresp, adapt_active;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans, adaptive_mode;
  logic [2:0]  hsize;
  logic [7:0]  content_ratio, gray_gain, backlight_level;
  wire         hready;
  int          error_cnt, tests_run, cyc;
  assign hready = hreadyout;
  bbc_top #(.RAMP_MS(RMS), .RAMP_CYCLES(RCY)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .soft_reset(soft_reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sleep_in(sleep_in), .content_ratio(content_ratio),
    .adaptive_mode(adaptive_mode), .adapt_active(adapt_active), .gray_gain(gray_gain),
    .backlight_level(backlight_level));
  bbc_light_model m_u (.hclk(hclk), .clr(mdl_clr), .level(backlight_level));
  // ********
  // tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one single transfer; the master never assumes a latency, only the timeout ends a wait
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    v = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(nm, v, exp);
  endtask
  // sample a little after the edge so outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  task automatic final_report;
    if (error_cnt == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // a hang counts as a mismatch
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      final_report;
    end
  end
  // ********
  // scenarios
  // ********
  initial begin
    {hresetn, soft_reset, hsel, hwrite, sleep_in, mdl_clr, htrans} = '0;
    {haddr, hwdata} = '0;
    hsize = 3'h2;
    content_ratio = 8'hff;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 4; i++) rchk("reset value", 8'(i * 4), 32'h0);
    rchk("unmapped read", 8'h40, 32'h0);
    wr(ADDR_CTRL, 32'h20);
    wr(ADDR_FLOOR, 32'h33);
    tick(2 * RCY);
    wr(ADDR_MANUAL, 32'h90);
    tick(3);
    chk("level undimmed", 32'(backlight_level), 32'h90);
    rchk("floor", ADDR_FLOOR, 32'h33);
    rchk("manual", ADDR_MANUAL, 32'h90);
    wr(ADDR_CTRL, 32'h28);
    // ramp up then down with the same shape
    for (int d = 0; d < 2; d++) begin
      mdl_clr <= 1'b1;
      tick(1);
      mdl_clr <= 1'b0;
      wr(ADDR_MANUAL, d ? 32'h00 : 32'hff);
      tick(RCY + 40);
      chk("step count", 32'(m_u.steps), 32'(NST));
      chk("shortest hold", 32'(m_u.min_hold), 32'(SLT));
      chk("longest hold", 32'(m_u.max_hold), 32'(SLT));
      chk("ramp end", 32'(backlight_level), d ? 32'h00 : 32'hff);
    end
    content_ratio <= 8'hb3;
    wr(ADDR_MANUAL, 32'h80);
    wr(ADDR_MODE, 32'h1);
    tick(2 * RCY + 20);
    chk("joint level", 32'(backlight_level), 32'h59);
    chk("gray gain", 32'(gray_gain), 32'hb3);
    wr(ADDR_CTRL, 32'h20);
    wr(ADDR_MANUAL, 32'h40);
    tick(3);
    chk("floored level", 32'(backlight_level), 32'h33);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("clamp flag", 32'(v[10]), 32'h1);
    wr(ADDR_MANUAL, 32'h20);
    tick(3);
    chk("manual below floor", 32'(backlight_level), 32'h20);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_MODE, 32'(m));
      tick(2);
      chk("mode", 32'(adaptive_mode), 32'(m));
      chk("adapting", 32'(adapt_active), 32'(m != 0));
    end
    sleep_in <= 1'b1;
    tick(2);
    chk("adapting in sleep", 32'(adapt_active), 32'h0);
    rchk("floor in sleep", ADDR_FLOOR, 32'h33);
    sleep_in <= 1'b0;
    wr(ADDR_CTRL, 32'h00);
    tick(3);
    chk("level off", 32'(backlight_level), 32'h0);
    chk("adapting off", 32'(adapt_active), 32'h0);
    // software reset in mid-run returns the stored controls to their defaults
    soft_reset <= 1'b1;
    tick(1);
    soft_reset <= 1'b0;
    rchk("floor after reset", ADDR_FLOOR, 32'(FLOOR_RST));
    rchk("manual after reset", ADDR_MANUAL, 32'(MANUAL_RST));
    final_report;
  end
endmodule
